// >>> reset_trace_exception_vectoring.sv
// Reset, trace and exception vectoring unit with a Wishbone register slave
//
// Local design decisions: the register addresses and the Wishbone register port.
`default_nettype none
// Overview of operation
// - Every exception source fetches from its own distinct vector slot.
// - Vectors: power-on 0, manual 1, trace 5, NMI 7, traps 8-11, IRQ 16-23.
// - Internal peripheral vectors occupy numbers 24 through 91.
// - Modes 6 and 7 limit ROM to 64 kbytes until the enable bit clears.
// - Reset wins over everything; pin low holds the unit in reset.
// - Any reset initializes CPU state and selects control mode 0.
// - Reset exception processing starts on the pin's low-to-high edge.
// - With manual reset support, NMI level picks power-on or manual for a pin reset.
// - Without manual reset support, every reset is power-on.
// - Manual reset spares bus controller and port registers.
// - Manual reset returns peripheral pins to general port I/O.
// - Reset entry clears trace bit, sets interrupt masks.
// - Reset vector is read into the program counter, then fetching starts.
// - All interrupts, NMI included, are blocked right after reset.
// - First instruction after reset always runs without interruption.
// - Reset release loads module stop register with 3fff.
// - Trace works only in control mode 2, never in mode 0.
// - Trace bit set raises a trace exception after each instruction.
// - Clearing the trace bit or leaving mode 2 ends trace; masking does not matter.
// - Interrupts stay accepted inside a trace handler.
// - Stacked trace bit stays set; no trace after return instruction.
// - Trace entry sets interrupt mask, clears trace, keeps other bits.
// - Traps and interrupts push state before the vector is fetched.
// - Priority: reset, then trace, then interrupt, then trap.
module reset_trace_exception_vectoring #(
    parameter bit MANUAL_RESET_SUPPORTED = 1'b1,
    parameter logic [23:0] ROM_EXT_LIMIT = 24'h01ffff
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic chip_init_pin_n_i,
    input wire logic nmi_pin_i,
    input wire logic wdt_init_req_i,
    input wire logic watchdog_init_select_i,
    input wire logic [3:0] op_mode_i,
    input wire logic insn_done_i,
    input wire logic insn_is_rte_i,
    input wire rstx_pkg::exc_flags_t rte_flags_i,
    input wire logic trap_req_i,
    input wire logic [1:0] trap_num_i,
    input wire logic int_req_i,
    input wire logic [6:0] int_vec_i,
    input wire logic push_done_i,
    input wire logic vec_ack_i,
    input wire logic [31:0] vec_data_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic cpu_halt_o,
    output logic push_req_o,
    output logic vec_req_o,
    output logic [23:0] vec_addr_o,
    output logic pc_load_o,
    output logic [31:0] pc_o,
    output rstx_pkg::exc_flags_t stack_flags_o,
    output rstx_pkg::exc_flags_t flags_o,
    output logic int_ack_o,
    output logic int_blocked_o,
    output logic [1:0] intm_o,
    output logic [15:0] module_stop_o,
    output logic [23:0] rom_limit_o,
    output logic periph_init_o,
    output logic busport_init_o,
    output logic pin_revert_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH = 3'b001,
        ST_VEC = 3'b011,
        ST_LOAD = 3'b010,
        ST_HOLD = 3'b110
    } state_t;

    function automatic logic [23:0] vec_addr(input logic [6:0] v);
        return {15'h0000, v, 2'b00};
    endfunction

    function automatic logic [31:0] wr_word(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    state_t state, next_state;
    logic [2:0] pin_sync, nmi_sync;
    logic pin_level, nmi_level, manual_hold, last_manual;
    logic [6:0] vnum;
    logic int_block, eae;
    logic [1:0] intm;
    logic [15:0] mstop;
    rstx_pkg::exc_flags_t flags, stack_flags;
    logic [23:0] vaddr;
    logic [31:0] pc;
    logic periph_init, busport_init, pin_revert, int_ack;
    logic [31:0] rd_data, ctrl_word, flags_word, status_word;

    // Pin inputs pass three flops; the level moves once stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync <= 3'h0;
            // NMI idles high, so a bare reset stays a power-on reset
            nmi_sync <= '1;
            pin_level <= 1'b0;
            nmi_level <= 1'b1;
        end else if (ce_i) begin
            pin_sync <= {pin_sync[1:0], chip_init_pin_n_i};
            nmi_sync <= {nmi_sync[1:0], nmi_pin_i};
            if (pin_sync[2] == pin_sync[1]) begin
                pin_level <= pin_sync[2];
            end
            if (nmi_sync[2] == nmi_sync[1]) begin
                nmi_level <= nmi_sync[2];
            end
        end
    end

    // Decoding of requests and exception selection
    wire in_pin_reset = !pin_level;
    wire idle_done = (state == ST_IDLE) && insn_done_i;
    wire wdt_fire = wdt_init_req_i && pin_level && (state != ST_HOLD);
    wire release_fire = (state == ST_HOLD) && pin_level;
    wire reset_start = release_fire || wdt_fire;
    wire t_bit = flags.extended_status_reg[rstx_pkg::EXR_T_BIT];
    wire mode2 = (intm == rstx_pkg::INTM_2);
    // An exception at a return boundary stacks the restored flags
    wire rstx_pkg::exc_flags_t base_flags =
        (idle_done && insn_is_rte_i) ? rte_flags_i : flags;
    // trace each boundary, mode 2 only
    wire trace_fire = idle_done && t_bit && mode2 && !insn_is_rte_i;
    // internal and external vectors in range
    wire int_vec_ok = (int_vec_i == rstx_pkg::VEC_NMI) ||
                      ((int_vec_i >= rstx_pkg::VEC_EXT_FIRST) &&
                       (int_vec_i <= rstx_pkg::VEC_INT_LAST));
    wire int_fire = idle_done && int_req_i && int_vec_ok && !int_block &&
                    !trace_fire;
    wire trap_fire = idle_done && trap_req_i && !trace_fire && !int_fire;
    wire take = (trace_fire || int_fire || trap_fire) && !wdt_fire;
    wire rte_fire = idle_done && insn_is_rte_i && !take && !wdt_fire;
    wire wdt_manual = MANUAL_RESET_SUPPORTED && watchdog_init_select_i;
    wire reset_manual = release_fire ? manual_hold : wdt_manual;
    wire [6:0] trap_vec = rstx_pkg::VEC_TRAP_BASE + {5'h00, trap_num_i};
    wire [6:0] next_vnum = reset_start ?
                           (reset_manual ? rstx_pkg::VEC_MANUAL :
                                           rstx_pkg::VEC_POWER_ON) :
                           trace_fire ? rstx_pkg::VEC_TRACE :
                           int_fire ? int_vec_i : trap_vec;

    always_comb begin
        next_state = state;
        if (in_pin_reset) begin
            next_state = ST_HOLD;
        end else if (reset_start) begin
            next_state = ST_VEC;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        next_state = ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (push_done_i) begin
                        next_state = ST_VEC;
                    end
                end
                ST_VEC: begin
                    if (vec_ack_i) begin
                        next_state = ST_LOAD;
                    end
                end
                ST_LOAD: next_state = ST_IDLE;
                ST_HOLD: next_state = ST_HOLD;
                default: next_state = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_HOLD;
            manual_hold <= 1'b0;
            last_manual <= 1'b0;
            vnum <= rstx_pkg::VEC_POWER_ON;
            vaddr <= vec_addr(rstx_pkg::VEC_POWER_ON);
        end else if (ce_i) begin
            state <= next_state;
            if (state == ST_HOLD) begin
                manual_hold <= MANUAL_RESET_SUPPORTED && !nmi_level;
            end
            if (reset_start) begin
                last_manual <= reset_manual;
            end
            // one slot per number, four bytes each
            if (reset_start || take) begin
                vnum <= next_vnum;
                vaddr <= vec_addr(next_vnum);
            end
        end
    end

    // vector word goes to the program counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= 32'h0000_0000;
        end else if (ce_i && state == ST_VEC && vec_ack_i) begin
            pc <= vec_data_i;
        end
    end

    // Register bus decode
    wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_hit && wb_we_i;
    wire wr_ctrl = wb_wr && (wb_adr_i == rstx_pkg::ADR_CTRL);
    wire wr_flags = wb_wr && (wb_adr_i == rstx_pkg::ADR_FLAGS);
    wire wr_mstop = wb_wr && (wb_adr_i == rstx_pkg::ADR_MSTOP);
    wire [31:0] new_ctrl = wr_word(ctrl_word, wb_dat_i, wb_sel_i);
    wire [31:0] new_flags = wr_word(flags_word, wb_dat_i, wb_sel_i);
    wire [31:0] new_mstop = wr_word({16'h0000, mstop}, wb_dat_i, wb_sel_i);

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[rstx_pkg::CTRL_INTM_LSB +: 2] = intm;
        ctrl_word[rstx_pkg::CTRL_EAE_BIT] = eae;
        flags_word = 32'h0000_0000;
        flags_word[rstx_pkg::FLAGS_CCR_LSB +: 8] = flags.condition_code_reg;
        flags_word[rstx_pkg::FLAGS_EXR_LSB +: 8] = flags.extended_status_reg;
        status_word = 32'h0000_0000;
        status_word[rstx_pkg::ST_VEC_LSB +: 7] = vnum;
        status_word[rstx_pkg::ST_MANUAL_BIT] = last_manual;
        status_word[rstx_pkg::ST_BLOCK_BIT] = int_block;
        status_word[rstx_pkg::ST_TRACE_BIT] = t_bit && mode2;
    end

    assign rd_data = (wb_adr_i == rstx_pkg::ADR_CTRL) ? ctrl_word :
                     (wb_adr_i == rstx_pkg::ADR_FLAGS) ? flags_word :
                     (wb_adr_i == rstx_pkg::ADR_MSTOP) ? {16'h0000, mstop} :
                     (wb_adr_i == rstx_pkg::ADR_STATUS) ? status_word :
                     (wb_adr_i == rstx_pkg::ADR_ROMLIM) ?
                     {8'h00, rom_limit_o} : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Control registers; hardware updates win over a same-cycle write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intm <= rstx_pkg::INTM_0;
            eae <= 1'b1;
            mstop <= rstx_pkg::MSTOP_RESET;
        end else if (ce_i) begin
            if (reset_start) begin
                // control mode 0 after any reset
                intm <= rstx_pkg::INTM_0;
                mstop <= rstx_pkg::MSTOP_RESET;
                // bus controller kept over a manual reset
                if (!reset_manual) begin
                    eae <= 1'b1;
                end
            end else begin
                if (wr_ctrl) begin
                    intm <= new_ctrl[rstx_pkg::CTRL_INTM_LSB +: 2];
                    eae <= new_ctrl[rstx_pkg::CTRL_EAE_BIT];
                end
                if (wr_mstop) begin
                    mstop <= new_mstop[15:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags.extended_status_reg <= rstx_pkg::EXR_RESET;
            flags.condition_code_reg <= rstx_pkg::CCR_RESET;
            stack_flags <= '0;
        end else if (ce_i) begin
            if (reset_start) begin
                flags.extended_status_reg[rstx_pkg::EXR_T_BIT] <= 1'b0;
                flags.extended_status_reg[rstx_pkg::EXR_MASK_LSB +: rstx_pkg::EXR_MASK_W]
                    <= rstx_pkg::MASK_ALL;
                flags.condition_code_reg[rstx_pkg::CCR_I_BIT] <= 1'b1;
            end else if (take) begin
                // stacked copy keeps the trace bit
                stack_flags <= base_flags;
                flags <= base_flags;
                // mask set, trace cleared in mode 2 only, UI and level kept
                flags.condition_code_reg[rstx_pkg::CCR_I_BIT] <= 1'b1;
                if (mode2) begin
                    flags.extended_status_reg[rstx_pkg::EXR_T_BIT] <= 1'b0;
                end
            end else if (rte_fire) begin
                // trace resumes from the restored bit
                flags <= rte_flags_i;
            end else if (wr_flags) begin
                flags.condition_code_reg <= new_flags[rstx_pkg::FLAGS_CCR_LSB +: 8];
                flags.extended_status_reg <= new_flags[rstx_pkg::FLAGS_EXR_LSB +: 8];
            end
        end
    end

    // interrupts blocked until first instruction completes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_block <= 1'b1;
        end else if (ce_i) begin
            if (reset_start || in_pin_reset) begin
                int_block <= 1'b1;
            end else if (idle_done) begin
                int_block <= 1'b0;
            end
        end
    end

    // One-cycle init strobes toward the peripherals, and the interrupt acknowledge toward the core
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_init <= 1'b0;
            busport_init <= 1'b0;
            pin_revert <= 1'b0;
            int_ack <= 1'b0;
        end else if (ce_i) begin
            periph_init <= reset_start;
            busport_init <= reset_start && !reset_manual;
            // pins back to general port I/O
            pin_revert <= reset_start && reset_manual;
            // interrupts taken regardless of a trace handler
            int_ack <= int_fire && !wdt_fire;
        end
    end

    assign cpu_halt_o = (state == ST_HOLD);
    assign push_req_o = (state == ST_PUSH);
    assign vec_req_o = (state == ST_VEC);
    assign pc_load_o = (state == ST_LOAD);
    assign vec_addr_o = vaddr;
    assign pc_o = pc;
    assign stack_flags_o = stack_flags;
    assign flags_o = flags;
    assign int_ack_o = int_ack;
    assign int_blocked_o = int_block;
    assign intm_o = intm;
    assign module_stop_o = mstop;
    assign periph_init_o = periph_init;
    assign busport_init_o = busport_init;
    assign pin_revert_o = pin_revert;
    // small ROM window in modes 6 and 7 while enable bit is set
    assign rom_limit_o = (((op_mode_i == rstx_pkg::MODE_6) ||
                           (op_mode_i == rstx_pkg::MODE_7)) && eae) ?
                         rstx_pkg::ROM_BASE_LIMIT : ROM_EXT_LIMIT;

    wire calm = ce_i && pin_level && !wdt_init_req_i;

    a_hold_in_reset: assert property (
        ce_i && !pin_level |=> state == ST_HOLD && cpu_halt_o)
        else $error("pin low did not hold reset");
    a_release_vec: assert property (
        ce_i && state == ST_HOLD && pin_level |=>
        state == ST_VEC && (vec_addr_o == vec_addr(rstx_pkg::VEC_POWER_ON) ||
        vec_addr_o == vec_addr(rstx_pkg::VEC_MANUAL)))
        else $error("release did not fetch reset vector");
    a_reset_type: assert property (
        ce_i && reset_start && !MANUAL_RESET_SUPPORTED |=>
        vnum == rstx_pkg::VEC_POWER_ON && !last_manual)
        else $error("manual reset without support");
    a_reset_flags: assert property (
        ce_i && reset_start |=> !flags.extended_status_reg[rstx_pkg::EXR_T_BIT] &&
        flags.condition_code_reg[rstx_pkg::CCR_I_BIT] && intm == rstx_pkg::INTM_0)
        else $error("reset entry flags wrong");
    a_mstop_load: assert property (
        ce_i && reset_start |=> module_stop_o == rstx_pkg::MSTOP_RESET)
        else $error("module stop not loaded");
    a_block_ints: assert property (
        int_block && int_req_i |=> !int_ack_o)
        else $error("interrupt taken while blocked");
    a_vec_to_pc: assert property (
        ce_i && state == ST_VEC && vec_ack_i && pin_level &&
        !wdt_init_req_i |=> pc_load_o && pc_o == $past(vec_data_i))
        else $error("vector not loaded to pc");
    a_trace_each: assert property (
        calm && idle_done && t_bit && mode2 && !insn_is_rte_i |=>
        state == ST_PUSH && vnum == rstx_pkg::VEC_TRACE)
        else $error("trace exception missing");
    a_trace_mode0: assert property (
        calm && idle_done && !mode2 |=>
        !(state == ST_PUSH && vnum == rstx_pkg::VEC_TRACE))
        else $error("trace outside mode 2");
    a_rte_no_trace: assert property (
        calm && idle_done && insn_is_rte_i |=> vnum != rstx_pkg::VEC_TRACE ||
        state != ST_PUSH)
        else $error("trace after return instruction");
    a_trace_entry: assert property (
        calm && trace_fire |=> flags.condition_code_reg[rstx_pkg::CCR_I_BIT] && !t_bit &&
        flags.condition_code_reg[rstx_pkg::CCR_UI_BIT] ==
        $past(flags.condition_code_reg[rstx_pkg::CCR_UI_BIT]) &&
        flags.extended_status_reg[rstx_pkg::EXR_MASK_LSB +: rstx_pkg::EXR_MASK_W] ==
        $past(flags.extended_status_reg[rstx_pkg::EXR_MASK_LSB +: rstx_pkg::EXR_MASK_W]))
        else $error("trace entry flags wrong");
    a_push_first: assert property (
        calm && state == ST_PUSH && !push_done_i |=> state == ST_PUSH &&
        !vec_req_o)
        else $error("vector fetched before push");
    a_priority: assert property (
        calm && trace_fire && int_req_i |=> vnum == rstx_pkg::VEC_TRACE)
        else $error("priority order broken");

    c_power_on: cover property (state == ST_HOLD ##1 state == ST_VEC);
    c_manual: cover property (pin_revert_o);
    c_trace: cover property (state == ST_PUSH &&
                             vnum == rstx_pkg::VEC_TRACE);
    c_interrupt: cover property (int_ack_o ##[1:20] pc_load_o);
endmodule
`default_nettype wire

// >>> reset_trace_exception_vectoring_tb.sv
// Self-checking bench of the exception entry unit
`default_nettype none
module reset_trace_exception_vectoring_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic ce_i = 1'h1;
    logic chip_init_pin_n_i, nmi_pin_i, cpu_halt_o, wb_ack_o, push_req_o;
    logic wdt_init_req_i = '0, watchdog_init_select_i = '0, insn_done_i = '0;
    logic insn_is_rte_i = '0, trap_req_i = '0, int_req_i = '0;
    logic push_done_i = '0, vec_ack_i = '0, wb_cyc_i = '0, wb_we_i = '0;
    logic vec_req_o, pc_load_o, int_blocked_o;
    logic int_ack_o, periph_init_o, busport_init_o, pin_revert_o;
    logic [3:0] op_mode_i = 4'h6;
    logic [1:0] trap_num_i = '0, intm_o;
    logic [6:0] int_vec_i = 7'h10;
    logic [7:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, vec_data_i = '0, wb_dat_o, pc_o, rd;
    logic [23:0] vec_addr_o, rom_limit_o;
    logic [15:0] module_stop_o;
    rstx_pkg::exc_flags_t rte_flags_i = '0, stack_flags_o, flags_o;
    int n_fail = 0, n_checks = 0, t;
    int n_ack = 0, n_init = 0, n_bp = 0, n_rev = 0;
    reset_trace_exception_vectoring i_reset_trace_exception_vectoring (
        .clk_i, .rst_i, .ce_i, .chip_init_pin_n_i, .nmi_pin_i,
        .wdt_init_req_i, .watchdog_init_select_i, .op_mode_i, .insn_done_i,
        .insn_is_rte_i, .rte_flags_i, .trap_req_i, .trap_num_i, .int_req_i,
        .int_vec_i, .push_done_i, .vec_ack_i, .vec_data_i, .wb_cyc_i,
        .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .cpu_halt_o, .push_req_o, .vec_req_o,
        .vec_addr_o, .pc_load_o, .pc_o, .stack_flags_o, .flags_o,
        .int_ack_o, .int_blocked_o, .intm_o, .module_stop_o, .rom_limit_o,
        .periph_init_o, .busport_init_o, .pin_revert_o);
    rst_source #(.HOLD(20)) i_rst_source (.clk_i,
        .chip_init_pin_n_o(chip_init_pin_n_i), .nmi_o(nmi_pin_i));
    always #5 clk_i = ~clk_i;
    // Strobe counts toward the core and the peripherals
    always @(posedge clk_i) begin
        if (!rst_i) begin
            n_ack += int_ack_o;
            n_init += periph_init_o;
            n_bp += busport_init_o;
            n_rev += pin_revert_o;
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
    endtask
    task automatic insn(input logic is_rte, input logic is_trap);
        @(posedge clk_i);
        insn_done_i <= 1'h1;
        insn_is_rte_i <= is_rte;
        trap_req_i <= is_trap;
        trap_num_i <= 2'($urandom);
        @(posedge clk_i);
        insn_done_i <= 1'h0;
        trap_req_i <= 1'h0;
    endtask
    task automatic quiet;
        @(posedge clk_i);
        chk("no_exception", {push_req_o, vec_req_o}, 0);
    endtask
    // Core side of an exception entry: stacking, vector read, PC load
    task automatic take(input int v, input logic pushed);
        if (pushed) begin
            do @(posedge clk_i); while (push_req_o !== 1'h1);
            chk("vec_before_push", vec_req_o, 0);
            push_done_i <= 1'h1;
            @(posedge clk_i);
            push_done_i <= 1'h0;
        end
        do @(posedge clk_i); while (vec_req_o !== 1'h1);
        chk("vec_addr", vec_addr_o, v * 4);
        vec_data_i <= $urandom;
        vec_ack_i <= 1'h1;
        @(posedge clk_i);
        vec_ack_i <= 1'h0;
        @(posedge clk_i);
        chk("pc_load", pc_load_o, 1);
        chk("pc", pc_o, vec_data_i);
    endtask
    initial begin
        #50000;
        n_fail++;
        end_of_test();
    end
    initial begin
        t = $urandom(32'h0a9d61ba);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        i_rst_source.pulse(1'h1);
        take(0, 0);
        chk("flags", flags_o, 16'h0780);
        chk("intm", intm_o, 0);
        chk("mstop", module_stop_o, 16'h3fff);
        chk("blocked", int_blocked_o, 1);
        wb(1, rstx_pkg::ADR_FLAGS, 0);
        wb(1, rstx_pkg::ADR_CTRL, 32'h102);
        int_req_i <= 1'h1;
        insn(0, 0);
        quiet();
        chk("unblocked", int_blocked_o, 0);
        insn(0, 0);
        take(16, 1);
        int_vec_i <= 7'h07;
        wb(1, rstx_pkg::ADR_FLAGS, 32'h8300);
        insn(0, 0);
        take(5, 1);
        chk("trace_flags", flags_o, 16'h0380);
        chk("stacked", stack_flags_o, 16'h8300);
        insn(0, 0);
        take(7, 1);
        int_req_i <= 1'h0;
        rte_flags_i <= 16'h8300;
        wb(1, rstx_pkg::ADR_FLAGS, 32'h8300);
        insn(1, 0);
        quiet();
        insn(0, 0);
        take(5, 1);
        wb(1, rstx_pkg::ADR_CTRL, 32'h100);
        wb(1, rstx_pkg::ADR_FLAGS, 32'h8300);
        insn(0, 0);
        quiet();
        insn(0, 1);
        take(8 + trap_num_i, 1);
        chk("rom", rom_limit_o, 24'h00ffff);
        wb(1, rstx_pkg::ADR_CTRL, 0);
        chk("rom_open", rom_limit_o, 24'h01ffff);
        wb(0, rstx_pkg::ADR_ROMLIM, 0);
        chk("romlim_rd", rd, 32'h01ffff);
        wb(0, 8'h40, 0);
        chk("unmapped", rd, 0);
        wb(1, rstx_pkg::ADR_MSTOP, 0);
        i_rst_source.pulse(1'h0);
        take(1, 0);
        wb(0, rstx_pkg::ADR_STATUS, 0);
        chk("status", rd, 32'h0301);
        chk("mstop_m", module_stop_o, 16'h3fff);
        chk("rom_kept", rom_limit_o, 24'h01ffff);
        wdt_init_req_i <= 1'h1;
        @(posedge clk_i);
        wdt_init_req_i <= 1'h0;
        take(0, 0);
        chk("rom_po", rom_limit_o, 24'h00ffff);
        chk("int_acks", n_ack, 2);
        chk("inits", n_init, 3);
        chk("busport", n_bp, 2);
        chk("reverts", n_rev, 1);
        end_of_test();
    end
endmodule
`default_nettype wire

// >>> rst_source.sv
// Board reset circuit and NMI source driving the unit's pins
`default_nettype none
module rst_source #(
    parameter int HOLD = 20
) (
    input wire logic clk_i,
    output logic chip_init_pin_n_o,
    output logic nmi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        chip_init_pin_n_o = 1'h0;
        nmi_o = 1'h1;
    end
    task automatic pulse(input logic nmi_lvl);
        @(posedge clk_i);
        nmi_o <= nmi_lvl;
        chip_init_pin_n_o <= 1'h0;
        repeat (HOLD) @(posedge clk_i);
        chip_init_pin_n_o <= 1'h1;
        // NMI level stays until the release has passed the synchronisers
        repeat (8) @(posedge clk_i);
        nmi_o <= 1'h1;
    endtask
endmodule
`default_nettype wire

// >>> rstx_pkg.sv
// Shared constants and types of the exception entry unit
`default_nettype none
package rstx_pkg;
    // Vector numbers, one slot per source
    localparam logic [6:0] VEC_POWER_ON = 7'h00;
    localparam logic [6:0] VEC_MANUAL = 7'h01;
    localparam logic [6:0] VEC_TRACE = 7'h05;
    localparam logic [6:0] VEC_NMI = 7'h07;
    localparam logic [6:0] VEC_TRAP_BASE = 7'h08;
    localparam logic [6:0] VEC_EXT_FIRST = 7'h10;
    localparam logic [6:0] VEC_EXT_LAST = 7'h17;
    localparam logic [6:0] VEC_INT_FIRST = 7'h18;
    localparam logic [6:0] VEC_INT_LAST = 7'h5b;
    // Interrupt control modes
    localparam logic [1:0] INTM_0 = 2'h0;
    localparam logic [1:0] INTM_2 = 2'h2;
    // Flag bit positions
    localparam int CCR_I_BIT = 7;
    localparam int CCR_UI_BIT = 6;
    localparam int EXR_T_BIT = 7;
    localparam int EXR_MASK_LSB = 0;
    localparam int EXR_MASK_W = 3;
    localparam logic [2:0] MASK_ALL = 3'h7;
    // Reset values
    localparam logic [7:0] CCR_RESET = 8'h80;
    localparam logic [7:0] EXR_RESET = 8'h07;
    localparam logic [15:0] MSTOP_RESET = 16'h3fff;
    // Memory limits
    localparam logic [23:0] ROM_BASE_LIMIT = 24'h00ffff;
    localparam logic [3:0] MODE_6 = 4'h6;
    localparam logic [3:0] MODE_7 = 4'h7;
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_FLAGS = 8'h04;
    localparam logic [7:0] ADR_MSTOP = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0c;
    localparam logic [7:0] ADR_ROMLIM = 8'h10;
    // Register field positions
    localparam int CTRL_INTM_LSB = 0;
    localparam int CTRL_EAE_BIT = 8;
    localparam int FLAGS_CCR_LSB = 0;
    localparam int FLAGS_EXR_LSB = 8;
    localparam int ST_VEC_LSB = 0;
    localparam int ST_MANUAL_BIT = 8;
    localparam int ST_BLOCK_BIT = 9;
    localparam int ST_TRACE_BIT = 10;
    // Status bytes that travel to and from the stack
    typedef struct packed {
        logic [7:0] extended_status_reg;
        logic [7:0] condition_code_reg;
    } exc_flags_t;
endpackage
`default_nettype wire
